//--- cesc_map.vh
// Contract
// R1: each channel's switching cycle starts, with its switch drive asserted, on the rising edge of that channel's clock.
// R2: the switching cycle ends, with the switch drive released, once sensed current plus slope ramp exceeds the compensator voltage.
// R3: while the enable pin is low the block stays in shutdown with regulators off and all configuration registers at reset values.
// R4: there is one software enable bit per channel, and a channel runs only while the enable pin is high and its bit is 1.
// R5: a channel stays off unless its dimming signal, from pin or internal source, is high and its reference code exceeds eight.
// R6: when the sync-enable bit is 1 the main clock follows the external square wave on the sync input, supplied at the wanted rate.
// R7: each channel clock is the main clock divided by the programmed division factor.
// R8: spread spectrum drives the oscillator reference from an 8-bit counter whose rate and depth are software fields.
// R9: the modulation frequency equals the main clock divided by the programmed modulation divisor.
// R10: every write to the modulation configuration register resets the modulation counter to its nominal start value.
// R11: the modulation counter ramps up then down between start and a depth limit, one triangle per modulation period.
`ifndef CESC_MAP_VH
`define CESC_MAP_VH
`define CESC_ADDR_EN      12'h000
`define CESC_ADDR_CLK     12'h004
`define CESC_ADDR_DIV     12'h008
`define CESC_ADDR_FM      12'h00c
`define CESC_ADDR_REF1    12'h010
`define CESC_ADDR_REF2    12'h014
`define CESC_ADDR_STAT    12'h018
`define CESC_EN_CH1_BIT   0
`define CESC_EN_CH2_BIT   1
`define CESC_EN_SWDIM1    2
`define CESC_EN_SWDIM2    3
`define CESC_CLK_SYNC_BIT 0
`define CESC_CLK_SS_BIT   1
`define CESC_CLK_OSCDIV_RST 16'h0019
`define CESC_DIV_RST      8'h04
`define CESC_FM_RATE_LSB  0
`define CESC_FM_RATE_MSB  15
`define CESC_FM_DEPTH_LSB 16
`define CESC_FM_DEPTH_MSB 23
`define CESC_FM_RST       32'h0010_0040
`define CESC_REF_RST      8'h00
`define CESC_REF_MIN_OFF  8'h08
`define CESC_MOD_START    8'h80
`endif

//--- cesc_chan.v
`timescale 1ns/1ps
`include "cesc_map.vh"
// one channel: clock divider and switching-cycle framing
module cesc_chan #(
    parameter DIVW = 8
) (
    input  wire            pclk,
    input  wire            presetn,
    input  wire            clkm_tick,
    input  wire [DIVW-1:0] div_factor,
    input  wire            run_ok,
    input  wire            comp_trip,
    output reg             ch_clk_r,
    output reg             drive_r
);
    reg  [DIVW-1:0] cnt_r;
    wire            wrap = (cnt_r >= div_factor - 1'b1) || (div_factor == {DIVW{1'b0}});
    wire            rise = clkm_tick && wrap;

    // divide main-clock ticks by the factor; clock high for the first half
    // an undivided clock must still fall between ticks, else it never rises again
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r    <= {DIVW{1'b0}};
            ch_clk_r <= 1'b0;
        end else if (clkm_tick) begin
            cnt_r    <= wrap ? {DIVW{1'b0}} : cnt_r + 1'b1; // R7
            ch_clk_r <= wrap || ((cnt_r + 1'b1) < (div_factor >> 1));
        end else if (div_factor <= {{(DIVW-1){1'b0}}, 1'b1}) begin
            ch_clk_r <= 1'b0; // R7
        end
    end

    // trip ends the cycle; a new clock edge restarts it even when tripping now
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= 1'b0;
        end else if (!run_ok) begin
            drive_r <= 1'b0;
        end else if (rise) begin
            drive_r <= 1'b1; // R1
        end else if (comp_trip) begin
            drive_r <= 1'b0; // R2
        end
    end
endmodule

//--- cesc_top.v
`timescale 1ns/1ps
`include "cesc_map.vh"
// enable gating, main-clock source, spread spectrum and two channels
module cesc_top #(
    parameter DIVW = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        en_pin,
    input  wire        sync_in,
    input  wire        dim_pin1,
    input  wire        dim_pin2,
    input  wire        trip1,
    input  wire        trip2,
    output reg         reg_on_r,
    output reg  [7:0]  osc_ref_r,
    output reg         clkm_r,
    output reg         ch_clk1_r,
    output reg         ch_clk2_r,
    output reg         drive1_r,
    output reg         drive2_r
);
    reg  [3:0]      en_r;
    reg  [1:0]      clkcfg_r;
    reg  [15:0]     oscdiv_r;
    reg  [DIVW-1:0] div_r;
    reg  [31:0]     fm_r;
    reg  [7:0]      ref1_r;
    reg  [7:0]      ref2_r;
    reg             fm_wr_r;
    reg  [15:0]     osc_cnt_r;
    reg             sync_d_r;
    reg  [15:0]     fm_cnt_r;
    reg  [7:0]      mod_r;
    reg             mod_up_r;
    wire            ch1_clk;
    wire            ch2_clk;
    wire            ch1_drv;
    wire            ch2_drv;

    // a reference code at or below the off level holds the channel off
    function ref_ok;
        input [7:0] code;
        begin
            ref_ok = code > `CESC_REF_MIN_OFF;
        end
    endfunction

    wire acc   = psel && penable && pready;
    wire wr    = acc && pwrite;
    wire known = (paddr == `CESC_ADDR_EN) || (paddr == `CESC_ADDR_CLK) ||
                 (paddr == `CESC_ADDR_DIV) || (paddr == `CESC_ADDR_FM) ||
                 (paddr == `CESC_ADDR_REF1) || (paddr == `CESC_ADDR_REF2) ||
                 (paddr == `CESC_ADDR_STAT);

    // apb handshake: one wait state, ready in the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !known;
        end
    end

    // config registers; shutdown pin clears them all like a reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r     <= 4'h0;
            clkcfg_r <= 2'h0;
            oscdiv_r <= `CESC_CLK_OSCDIV_RST;
            div_r    <= `CESC_DIV_RST;
            fm_r     <= `CESC_FM_RST;
            ref1_r   <= `CESC_REF_RST;
            ref2_r   <= `CESC_REF_RST;
            fm_wr_r  <= 1'b0;
        end else if (!en_pin) begin
            en_r     <= 4'h0; // R3
            clkcfg_r <= 2'h0; // R3
            oscdiv_r <= `CESC_CLK_OSCDIV_RST;
            div_r    <= `CESC_DIV_RST;
            fm_r     <= `CESC_FM_RST;
            ref1_r   <= `CESC_REF_RST;
            ref2_r   <= `CESC_REF_RST;
            fm_wr_r  <= 1'b0;
        end else begin
            fm_wr_r <= 1'b0;
            if (wr) begin
                if (paddr == `CESC_ADDR_EN) begin
                    en_r <= pwdata[3:0]; // R4
                end else if (paddr == `CESC_ADDR_CLK) begin
                    clkcfg_r <= pwdata[1:0];
                    oscdiv_r <= pwdata[31:16];
                end else if (paddr == `CESC_ADDR_DIV) begin
                    div_r <= pwdata[DIVW-1:0];
                end else if (paddr == `CESC_ADDR_FM) begin
                    fm_r    <= pwdata & 32'h00ff_ffff; // R8
                    fm_wr_r <= 1'b1; // R10
                end else if (paddr == `CESC_ADDR_REF1) begin
                    ref1_r <= pwdata[7:0];
                end else if (paddr == `CESC_ADDR_REF2) begin
                    ref2_r <= pwdata[7:0];
                end
            end
        end
    end

    // read mux; registered so prdata comes from a flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready && !pwrite) begin
            if (paddr == `CESC_ADDR_EN) begin
                prdata <= {28'h0000000, en_r};
            end else if (paddr == `CESC_ADDR_CLK) begin
                prdata <= {oscdiv_r, 14'h0000, clkcfg_r};
            end else if (paddr == `CESC_ADDR_DIV) begin
                prdata <= {{(32-DIVW){1'b0}}, div_r};
            end else if (paddr == `CESC_ADDR_FM) begin
                prdata <= fm_r;
            end else if (paddr == `CESC_ADDR_REF1) begin
                prdata <= {24'h000000, ref1_r};
            end else if (paddr == `CESC_ADDR_REF2) begin
                prdata <= {24'h000000, ref2_r};
            end else if (paddr == `CESC_ADDR_STAT) begin
                prdata <= {16'h0000, mod_r, 2'h0, ch2_drv, ch1_drv,
                           ch2_clk, ch1_clk, en_pin, reg_on_r};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // sync input edge, taken as synchronous
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_in;
        end
    end
    wire sync_rise = sync_in && !sync_d_r;

    // internal oscillator: period = base divide plus spread offset from the reference
    wire [15:0] osc_period = oscdiv_r + (clkcfg_r[`CESC_CLK_SS_BIT] ?
                             {8'h00, mod_r} - {8'h00, `CESC_MOD_START} : 16'h0000);
    wire        osc_wrap   = (osc_cnt_r >= osc_period);
    wire        clkm_tick  = clkcfg_r[`CESC_CLK_SYNC_BIT] ? sync_rise : osc_wrap; // R6

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_r <= 16'h0000;
            clkm_r    <= 1'b0;
        end else begin
            osc_cnt_r <= osc_wrap ? 16'h0000 : osc_cnt_r + 1'b1;
            clkm_r    <= clkm_tick;
        end
    end

    // triangle modulation: one step per divisor/(2*depth) main ticks, counted by
    // fm_cnt_r, turning at the limit; divisor sets period
    wire [15:0] rate  = fm_r[`CESC_FM_RATE_MSB:`CESC_FM_RATE_LSB];
    wire [7:0]  depth = fm_r[`CESC_FM_DEPTH_MSB:`CESC_FM_DEPTH_LSB];
    wire [15:0] step_div = (depth == 8'h00) ? rate : rate / {7'h00, depth, 1'b0};
    wire        step  = clkm_tick && (fm_cnt_r + 1'b1 >= step_div);
    wire [7:0]  top   = `CESC_MOD_START + depth;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fm_cnt_r <= 16'h0000;
            mod_r    <= `CESC_MOD_START;
            mod_up_r <= 1'b1;
        end else if (fm_wr_r || !en_pin) begin
            fm_cnt_r <= 16'h0000; // R10
            mod_r    <= `CESC_MOD_START; // R10
            mod_up_r <= 1'b1;
        end else if (clkm_tick) begin
            fm_cnt_r <= step ? 16'h0000 : fm_cnt_r + 1'b1; // R9
            if (step && depth != 8'h00) begin
                if (mod_up_r) begin
                    mod_r    <= mod_r + 1'b1; // R11
                    mod_up_r <= (mod_r + 1'b1) < top;
                end else begin
                    mod_r    <= mod_r - 1'b1; // R11
                    mod_up_r <= (mod_r - 1'b1) <= `CESC_MOD_START;
                end
            end
        end
    end

    // channel gating: pin, bit, dimming and reference code all required
    wire dim1 = dim_pin1 || en_r[`CESC_EN_SWDIM1];
    wire dim2 = dim_pin2 || en_r[`CESC_EN_SWDIM2];
    wire run1 = en_pin && en_r[`CESC_EN_CH1_BIT] && dim1 && ref_ok(ref1_r); // R4 R5
    wire run2 = en_pin && en_r[`CESC_EN_CH2_BIT] && dim2 && ref_ok(ref2_r); // R4 R5

    cesc_chan #(.DIVW(DIVW)) u_ch1 (
        .pclk       (pclk),
        .presetn    (presetn),
        .clkm_tick  (clkm_tick),
        .div_factor (div_r),
        .run_ok     (run1),
        .comp_trip  (trip1),
        .ch_clk_r   (ch1_clk),
        .drive_r    (ch1_drv)
    );

    cesc_chan #(.DIVW(DIVW)) u_ch2 (
        .pclk       (pclk),
        .presetn    (presetn),
        .clkm_tick  (clkm_tick),
        .div_factor (div_r),
        .run_ok     (run2),
        .comp_trip  (trip2),
        .ch_clk_r   (ch2_clk),
        .drive_r    (ch2_drv)
    );

    // output flops; regulators follow the enable pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_on_r  <= 1'b0;
            osc_ref_r <= `CESC_MOD_START;
            ch_clk1_r <= 1'b0;
            ch_clk2_r <= 1'b0;
            drive1_r  <= 1'b0;
            drive2_r  <= 1'b0;
        end else begin
            reg_on_r  <= en_pin; // R3
            osc_ref_r <= mod_r; // R8
            ch_clk1_r <= ch1_clk;
            ch_clk2_r <= ch2_clk;
            drive1_r  <= ch1_drv;
            drive2_r  <= ch2_drv;
        end
    end
endmodule

//--- cesc_properties.sv
`timescale 1ns/1ps
// watches bus timing, switch framing, shutdown and the modulation counter
module cesc_properties (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic        pready,
    input logic        pslverr,
    input logic        en_pin,
    input logic        trip1,
    input logic        clkm_r,
    input logic        drive1_r,
    input logic        drive2_r,
    input logic        reg_on_r,
    input logic [7:0]  osc_ref_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a completed write to the modulation register while powered
    sequence s_fm_wr;
        psel && penable && pready && pwrite && paddr == 12'h00c && en_pin;
    endsequence
    // trip held with no main tick that could restart the cycle
    sequence s_trip_held;
        (trip1 && !clkm_r) [*4];
    endsequence
    sequence s_pin_off;
        !en_pin [*3];
    endsequence

    chk_ready_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not one cycle after access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_unmapped_err: assert property (pready && paddr > 12'h018 |-> pslverr)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (pready && paddr <= 12'h018 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    chk_drive_start: assert property ($rose(drive1_r) |-> $past(clkm_r) && $past(en_pin, 2))
        else $error("drive rose without a clock tick");
    chk_drive_end: assert property (s_trip_held |-> !drive1_r)
        else $error("drive stayed on after trip");
    chk_shutdown_off: assert property (s_pin_off |-> !drive1_r && !drive2_r && !reg_on_r)
        else $error("activity while enable pin low");
    chk_fm_restart: assert property (s_fm_wr |-> ##3 osc_ref_r == 8'h80)
        else $error("modulation counter not restarted");
    chk_ref_floor: assert property (osc_ref_r >= 8'h80)
        else $error("modulation counter below start");
endmodule

//--- channel_enable_and_spread_clock_test.sv
`timescale 1ns/1ps
// gating cases from a table, then clocking, spread and shutdown by hand
module channel_enable_and_spread_clock_test;
    typedef struct packed {logic [3:0] en; logic dim; logic [7:0] code; logic [1:0] exp;} cesc_row_t;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, en_pin = 1, sync_in = 0, dim = 0, hold = 0;
    logic        trip1 = 0, trip2 = 0, sync_run = 0, reg_on_r, clkm_r, ch_clk1_r, ch_clk2_r;
    logic        drive1_r, drive2_r, pv, p2;
    logic [7:0]  osc_ref_r, mx;
    logic [1:0]  seen;
    logic [31:0] dv [4] = '{32'h0, 32'h1, 32'h3, 32'h5};
    int          errors = 0, num_checks = 0, cyc = 0, n, m;
    cesc_row_t   rows [7] = '{'{4'h3, 1'b1, 8'h09, 2'b11}, '{4'h3, 1'b1, 8'h08, 2'b00},
        '{4'h1, 1'b1, 8'h09, 2'b01}, '{4'h2, 1'b1, 8'hff, 2'b10}, '{4'h3, 1'b0, 8'h09, 2'b00},
        '{4'hf, 1'b0, 8'h09, 2'b11}, '{4'h7, 1'b0, 8'h09, 2'b01}};

    cesc_top #(.DIVW(8)) i_cesc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .en_pin(en_pin), .sync_in(sync_in),
        .dim_pin1(dim), .dim_pin2(dim), .trip1(trip1), .trip2(trip2), .reg_on_r(reg_on_r),
        .osc_ref_r(osc_ref_r), .clkm_r(clkm_r), .ch_clk1_r(ch_clk1_r), .ch_clk2_r(ch_clk2_r),
        .drive1_r(drive1_r), .drive2_r(drive2_r));

    always #2 pclk = ~pclk;
    // comparator trips one cycle after each drive, ending every switching cycle
    always @(posedge pclk) begin
        trip1 <= drive1_r | hold;
        trip2 <= drive2_r | hold;
        cyc <= cyc + 1;
        if (sync_run && cyc % 5 == 0)
            sync_in <= ~sync_in;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits on pready, the timeout ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // records drives seen, main ticks and the highest modulation code
    task automatic watch(input int c);
        seen = 2'b00;
        mx   = 8'h00;
        n    = 0;
        repeat (c) begin
            @(posedge pclk);
            seen = seen | {drive2_r, drive1_r};
            n    = n + clkm_r;
            if (osc_ref_r > mx)
                mx = osc_ref_r;
        end
    endtask
    // main ticks in one channel clock period, and channel 2 rises once in it
    task automatic ticks;
        @(posedge ch_clk1_r);
        n  = 0;
        m  = 0;
        pv = 1'b1;
        p2 = 1'b1;
        do begin
            @(posedge pclk);
            n  = n + clkm_r;
            m  = m + (ch_clk2_r & ~p2);
            mx = {7'h0, ch_clk1_r & ~pv};
            pv = ch_clk1_r;
            p2 = ch_clk2_r;
        end while (mx[0] !== 1'b1);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd, 32'h0000_0004);
        apb(1'b0, 12'h00c, 32'h0);
        cmp(rd, 32'h0010_0040);
        apb(1'b0, 12'h01c, 32'h0);
        cmp({31'h0, err}, 32'h1);
        $display("reset values test done");
        // short oscillator period keeps each row brief
        apb(1'b1, 12'h004, 32'h0003_0000);
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, {28'h0, rows[i].en});
            apb(1'b1, 12'h010, {24'h0, rows[i].code});
            apb(1'b1, 12'h014, {24'h0, rows[i].code});
            dim <= rows[i].dim;
            watch(8);
            watch(120);
            cmp({30'h0, seen}, {30'h0, rows[i].exp});
        end
        $display("gating table done");
        foreach (dv[i]) begin
            apb(1'b1, 12'h008, dv[i]);
            ticks();
            ticks();
            cmp(n, (dv[i] == 0) ? 32'h1 : dv[i]);
            cmp(m, 32'h1);
        end
        $display("divider test done");
        apb(1'b1, 12'h004, 32'h0003_0001);
        sync_run <= 1'b1;
        watch(20);
        watch(200);
        cmp({31'h0, n >= 19 && n <= 21}, 32'h1);
        sync_run <= 1'b0;
        $display("sync test done");
        apb(1'b1, 12'h004, 32'h0003_0002);
        apb(1'b1, 12'h00c, 32'h0008_0040);
        watch(900);
        cmp({24'h0, mx}, 32'h88);
        apb(1'b1, 12'h00c, 32'h0008_0040);
        repeat (3) @(posedge pclk);
        cmp({24'h0, osc_ref_r}, 32'h80);
        $display("spread test done");
        hold <= 1'b1;
        watch(40);
        hold <= 1'b0;
        en_pin <= 1'b0;
        watch(4);
        watch(20);
        cmp({29'h0, seen, reg_on_r}, 32'h0);
        en_pin <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        cmp(rd, 32'h0010_0040);
        $display("trip and shutdown test done");
        conclude();
    end
endmodule

bind cesc_top cesc_properties i_cesc_properties (.*);
